// ---- hw/lpw_consts.svh ----
// Summary of operation
// (RULE_01) standby keeps resources, only core halted
// (RULE_02) armed sources: mask OR selected timer
// (RULE_03) code 0 none, 1 pulse, 2-13 slow
// (RULE_04) codes 14-269 fast, count times 10 us
// (RULE_05) fixed bit values of the source mask
// (RULE_06) slow timer and pulse share one bit
// (RULE_07) selected timer left running, interrupt off; code leaves the timer's irq_enable bit as firmware set it
// (RULE_08) matching low-speed oscillator left running
// (RULE_09) firmware reads and clears timer flags
// (RULE_10) same code keeps period, change may shorten
// (RULE_11) non-selectable variant wakes on anything
// (RULE_12) no-parameter variant standby: any enabled interrupt
// (RULE_13) that variant sleep exits on slow timer
// (RULE_14) slow timer reset, sleep lasts half period
// (RULE_15) firmware keeps sleep roughly 1 to 8 ms
// (RULE_16) firmware sets timer clock behaviour first
// (RULE_17) preconfigured timer: code none, mask bit
// (RULE_18) wake restores saved state, back active
// (RULE_19) source enables restored before return
// (RULE_20) status clears on read: fast 1, slow 2, pulse 4
// (RULE_21) firmware reads status within 1 ms
`ifndef LPW_CONSTS_SVH
`define LPW_CONSTS_SVH
// ==========================================================
// register map
`define LPW_OFS_CTRL      8'h00
`define LPW_OFS_WAKE_TIME 8'h04
`define LPW_OFS_WAKE_SRC  8'h08
`define LPW_OFS_STATUS    8'h0C
`define LPW_OFS_STATE     8'h10
`define LPW_OFS_SRC_EN    8'h14
`define LPW_OFS_IRQ_EN    8'h18
`define LPW_CTRL_STANDBY  0
`define LPW_CTRL_SLEEP    1
`define LPW_CTRL_VAR_LO   2
`define LPW_CTRL_VAR_HI   3
`define LPW_CTRL_EARLY    4
// ==========================================================
// fields and codes
`define LPW_SRC_W         13
`define LPW_CODE_W        9
`define LPW_SRC_GEN_IRQ   4
`define LPW_SRC_FAST      10
`define LPW_SRC_SLOW      11
`define LPW_SRC_VALID     13'h1EDF
`define LPW_SRC_ALL       13'h1FFF
`define LPW_STAT_FAST     0
`define LPW_STAT_SLOW     1
`define LPW_STAT_PPS      2
`define LPW_CODE_NONE     9'h000
`define LPW_CODE_PPS      9'h001
`define LPW_CODE_SLOW_LO  9'h002
`define LPW_CODE_SLOW_HI  9'h00D
`define LPW_CODE_FAST_HI  9'h10D
`define LPW_FAST_MAX_EARLY 9'h020
`define LPW_SRC_EN_RST    13'h0000
`define LPW_IRQ_EN_RST    13'h1FFF
// ==========================================================
// timing
`define LPW_CLK_NS        5
`define LPW_MS_NS         1000000
`define LPW_STEP_NS       10000
`define LPW_MS_CYCLES     (`LPW_MS_NS / `LPW_CLK_NS)
`define LPW_STEP_CYCLES   (`LPW_STEP_NS / `LPW_CLK_NS)
`define LPW_PPS_MS        13'h03E8
`endif

// ---- hw/lpw_pkg.sv ----
package lpw_pkg;
  typedef enum logic [3:0] {
    LPW_ST_ACTIVE  = 4'h1,
    LPW_ST_STANDBY = 4'h2,
    LPW_ST_SLEEP   = 4'h4,
    LPW_ST_RESTORE = 4'h8
  } lpw_state_t;
  typedef enum logic [1:0] {
    LPW_VAR_FULL    = 2'h0,
    LPW_VAR_NOSEL   = 2'h1,
    LPW_VAR_NOPARAM = 2'h2,
    LPW_VAR_SPARE   = 2'h3
  } lpw_variant_t;
endpackage

// ---- hw/lpw_period_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpw_period_timer
#(
  parameter int W = 13
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  output logic              expire
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         expire_reg;
  logic         expire_next;

  // ==========================================================
  // counter: period is limit ticks; a new limit is not a restart,
  // so a smaller one may end the running interval early
  always_comb
  begin
    cnt_next    = cnt_reg;
    expire_next = 1'b0;
    if (restart)
      cnt_next = '0;
    else if (run && tick)
    begin
      if ({1'b0, cnt_reg} + {{W{1'b0}}, 1'b1} >= {1'b0, limit}) // see RULE_10
      begin
        cnt_next    = '0;
        expire_next = 1'b1;
      end
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg    <= '0;
      expire_reg <= 1'b0;
    end
    else
    begin
      cnt_reg    <= cnt_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;

  a_expire_cause : assert property ( // see RULE_10
    @(posedge hclk) disable iff (!hresetn)
    expire |-> $past(run && tick && !restart))
    else $error("timer expired without a running tick");
  a_restart_zero : assert property ( // see RULE_14
    @(posedge hclk) disable iff (!hresetn)
    restart |=> (cnt_reg == '0) && !expire)
    else $error("restart did not clear the timer");
endmodule
`default_nettype wire

// ---- hw/lpw_wakeup_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lpw_consts.svh"
module lpw_wakeup_ctrl
#(
  parameter int MS_CYCLES = `LPW_MS_CYCLES
)
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic [`LPW_SRC_W-1:0]  wake_evt,
  output logic                        cpu_halt,
  output logic [`LPW_SRC_W-1:0]       wake_enable,
  output logic [`LPW_SRC_W-1:0]       irq_enable,
  output logic                        slow_osc_run,
  output logic                        fast_osc_run,
  output logic                        slow_wake_timer_run,
  output logic                        fast_wake_timer_run,
  output logic                        one_second_pulse_run,
  output lpw_pkg::lpw_state_t         lp_state
);
  import lpw_pkg::*;

  localparam int STEP_CYCLES = `LPW_STEP_CYCLES;

  function automatic logic [12:0] lpw_slow_period(input logic [8:0] c);
    lpw_slow_period = 13'h0001 << (c[3:0] - 4'h1);
  endfunction

  function automatic logic [12:0] lpw_fast_count(input logic [8:0] c, input logic early);
    logic [8:0] n;
    n = c - 9'h00D;
    if (early && n > `LPW_FAST_MAX_EARLY)
      n = `LPW_FAST_MAX_EARLY;
    lpw_fast_count = {4'h0, n};
  endfunction

  // ==========================================================
  // state
  lpw_state_t         state_reg, state_next;
  lpw_variant_t       variant_reg, variant_next;
  logic               early_reg, early_next;
  logic               req_sb_reg, req_sb_next, req_sl_reg, req_sl_next;
  logic [8:0]         code_reg, code_next;
  logic [12:0]        src_reg, src_next, src_en_reg, src_en_next;
  logic [12:0]        irq_en_reg, irq_en_next, saved_reg, saved_next;
  logic [12:0]        armed_reg, armed_next, wake_en_reg, wake_en_next;
  logic [12:0]        irq_out_reg, irq_out_next;
  logic [12:0]        slow_lim_reg, slow_lim_next, fast_lim_reg, fast_lim_next;
  logic [2:0]         stat_reg, stat_next;
  logic               halt_reg, halt_next, sosc_reg, sosc_next, fosc_reg, fosc_next;
  logic               srun_reg, srun_next, frun_reg, frun_next, prun_reg, prun_next;
  logic               slow_rst, slow_rst_next;
  logic               wr_pend_reg, wr_pend_next;
  logic [7:0]         wr_addr_reg, wr_addr_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic [31:0]        ms_cnt_reg, ms_cnt_next;
  logic [11:0]        step_cnt_reg, step_cnt_next;
  logic               ms_tick_reg, ms_tick_next, step_tick_reg, step_tick_next;
  logic               slow_exp, fast_exp, pps_exp;
  logic               addr_ok, rd_stat;
  logic [12:0]        evts;
  logic               wake;

  // ==========================================================
  // low-speed oscillator ticks, one-cycle enables
  always_comb
  begin
    ms_tick_next   = (ms_cnt_reg == 32'(MS_CYCLES - 1));
    ms_cnt_next    = ms_tick_next ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
    step_tick_next = (step_cnt_reg == 12'(STEP_CYCLES - 1));
    step_cnt_next  = step_tick_next ? 12'h000 : step_cnt_reg + 12'h001;
  end

  lpw_period_timer #(.W(13)) u_slow (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (ms_tick_reg & sosc_reg),
    .run     (srun_reg),
    .restart (slow_rst),
    .limit   (slow_lim_reg),
    .expire  (slow_exp)
  );
  lpw_period_timer #(.W(13)) u_fast (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (step_tick_reg & fosc_reg),
    .run     (frun_reg),
    .restart (1'b0),
    .limit   (fast_lim_reg),
    .expire  (fast_exp)
  );
  lpw_period_timer #(.W(13)) u_pps (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (ms_tick_reg),
    .run     (prun_reg),
    .restart (1'b0),
    .limit   (`LPW_PPS_MS),
    .expire  (pps_exp)
  );

  // ==========================================================
  // bus decode, registers and power-mode sequence
  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_stat = addr_ok && !hwrite && (haddr[7:0] == `LPW_OFS_STATUS);
  always_comb
  begin
    evts                 = wake_evt;
    evts[`LPW_SRC_FAST]  = wake_evt[`LPW_SRC_FAST] | fast_exp;
    evts[`LPW_SRC_SLOW]  = wake_evt[`LPW_SRC_SLOW] | slow_exp | pps_exp; // see RULE_06
    wake                 = |(armed_reg & evts);
  end

  always_comb
  begin
    state_next   = state_reg;
    variant_next = variant_reg;
    early_next   = early_reg;
    req_sb_next  = 1'b0;
    req_sl_next  = 1'b0;
    code_next    = code_reg;
    src_next     = src_reg;
    src_en_next  = src_en_reg;
    irq_en_next  = irq_en_reg;
    saved_next   = saved_reg;
    armed_next   = armed_reg;
    wake_en_next = wake_en_reg;
    irq_out_next = irq_out_reg;
    slow_lim_next = slow_lim_reg;
    fast_lim_next = fast_lim_reg;
    halt_next    = halt_reg;
    sosc_next    = sosc_reg;
    fosc_next    = fosc_reg;
    srun_next    = srun_reg;
    frun_next    = frun_reg;
    prun_next    = prun_reg;
    slow_rst_next = 1'b0;
    wr_pend_next = addr_ok && hwrite;
    wr_addr_next = haddr[7:0];
    rdata_next   = rdata_reg;
    // set wins over the read clear so no event is lost
    stat_next    = (rd_stat ? 3'h0 : stat_reg) | {pps_exp, slow_exp, fast_exp}; // see RULE_20
    if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        `LPW_OFS_CTRL:      rdata_next = {27'h0, early_reg, variant_reg, 2'h0};
        `LPW_OFS_WAKE_TIME: rdata_next = {23'h0, code_reg};
        `LPW_OFS_WAKE_SRC:  rdata_next = {19'h0, src_reg};
        `LPW_OFS_STATUS:    rdata_next = {29'h0, stat_reg}; // see RULE_20
        `LPW_OFS_STATE:     rdata_next = {23'h0, prun_reg, frun_reg, srun_reg, fosc_reg,
                                          sosc_reg, state_reg};
        `LPW_OFS_SRC_EN:    rdata_next = {19'h0, src_en_reg};
        `LPW_OFS_IRQ_EN:    rdata_next = {19'h0, irq_en_reg};
        default:            rdata_next = 32'h00000000;
      endcase
    end
    if (wr_pend_reg)
    begin
      unique case (wr_addr_reg)
        `LPW_OFS_CTRL:
        begin
          req_sb_next  = hwdata[`LPW_CTRL_STANDBY];
          req_sl_next  = hwdata[`LPW_CTRL_SLEEP];
          variant_next = lpw_variant_t'(hwdata[`LPW_CTRL_VAR_HI:`LPW_CTRL_VAR_LO]);
          early_next   = hwdata[`LPW_CTRL_EARLY];
        end
        `LPW_OFS_WAKE_TIME: code_next = hwdata[8:0];
        `LPW_OFS_WAKE_SRC:  src_next = hwdata[12:0] & `LPW_SRC_VALID; // see RULE_05
        `LPW_OFS_SRC_EN:    src_en_next = hwdata[12:0];
        `LPW_OFS_IRQ_EN:    irq_en_next = hwdata[12:0];
        default:            ;
      endcase
    end
    unique case (state_reg)
      LPW_ST_ACTIVE:
      begin
        wake_en_next = src_en_reg;
        irq_out_next = irq_en_reg;
        if (req_sb_reg || req_sl_reg)
        begin
          halt_next  = 1'b1; // see RULE_01
          saved_next = src_en_reg; // see RULE_18
          state_next = req_sb_reg ? LPW_ST_STANDBY : LPW_ST_SLEEP;
          armed_next = src_reg; // see RULE_02
          if (variant_reg == LPW_VAR_NOPARAM)
          begin
            if (req_sb_reg)
              armed_next = irq_en_reg; // see RULE_12
            else
            begin
              armed_next    = 13'h0001 << `LPW_SRC_SLOW; // see RULE_13
              irq_out_next  = 13'h0000; // see RULE_13
              slow_rst_next = 1'b1; // see RULE_14
              slow_lim_next = (slow_lim_reg > 13'h0001) ? slow_lim_reg >> 1 : 13'h0001;
            end
          end
          else
          begin
            // timers stay enabled after exit; the same code keeps phase
            if (code_reg == `LPW_CODE_PPS)
            begin
              prun_next  = 1'b1; // see RULE_07
              armed_next[`LPW_SRC_SLOW] = 1'b1; // see RULE_06
            end
            else if (code_reg >= `LPW_CODE_SLOW_LO && code_reg <= `LPW_CODE_SLOW_HI)
            begin
              slow_lim_next = lpw_slow_period(code_reg); // see RULE_03
              srun_next  = 1'b1; // see RULE_07
              sosc_next  = 1'b1; // see RULE_08
              armed_next[`LPW_SRC_SLOW] = 1'b1; // see RULE_02
            end
            else if (code_reg > `LPW_CODE_SLOW_HI && code_reg <= `LPW_CODE_FAST_HI)
            begin
              fast_lim_next = lpw_fast_count(code_reg, early_reg); // see RULE_04
              frun_next  = 1'b1; // see RULE_07
              fosc_next  = 1'b1; // see RULE_08
              armed_next[`LPW_SRC_FAST] = 1'b1; // see RULE_02
            end
            if (variant_reg == LPW_VAR_NOSEL)
              armed_next = `LPW_SRC_ALL; // see RULE_11
          end
          wake_en_next = armed_next;
        end
      end
      LPW_ST_STANDBY, LPW_ST_SLEEP:
        if (wake)
          state_next = LPW_ST_RESTORE; // see RULE_18
      LPW_ST_RESTORE:
      begin
        wake_en_next = saved_reg; // see RULE_19
        irq_out_next = irq_en_reg; // see RULE_13
        halt_next    = 1'b0;
        state_next   = LPW_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg     <= LPW_ST_ACTIVE;
      variant_reg   <= LPW_VAR_FULL;
      early_reg     <= 1'b0;
      req_sb_reg    <= 1'b0;
      req_sl_reg    <= 1'b0;
      code_reg      <= `LPW_CODE_NONE;
      src_reg       <= 13'h0000;
      src_en_reg    <= `LPW_SRC_EN_RST;
      irq_en_reg    <= `LPW_IRQ_EN_RST;
      saved_reg     <= `LPW_SRC_EN_RST;
      armed_reg     <= 13'h0000;
      wake_en_reg   <= `LPW_SRC_EN_RST;
      irq_out_reg   <= `LPW_IRQ_EN_RST;
      slow_lim_reg  <= 13'h0001;
      fast_lim_reg  <= 13'h0001;
      stat_reg      <= 3'h0;
      halt_reg      <= 1'b0;
      sosc_reg      <= 1'b0;
      fosc_reg      <= 1'b0;
      srun_reg      <= 1'b0;
      frun_reg      <= 1'b0;
      prun_reg      <= 1'b0;
      slow_rst      <= 1'b0;
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      rdata_reg     <= 32'h00000000;
      ms_cnt_reg    <= 32'h00000000;
      step_cnt_reg  <= 12'h000;
      ms_tick_reg   <= 1'b0;
      step_tick_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      variant_reg   <= variant_next;
      early_reg     <= early_next;
      req_sb_reg    <= req_sb_next;
      req_sl_reg    <= req_sl_next;
      code_reg      <= code_next;
      src_reg       <= src_next;
      src_en_reg    <= src_en_next;
      irq_en_reg    <= irq_en_next;
      saved_reg     <= saved_next;
      armed_reg     <= armed_next;
      wake_en_reg   <= wake_en_next;
      irq_out_reg   <= irq_out_next;
      slow_lim_reg  <= slow_lim_next;
      fast_lim_reg  <= fast_lim_next;
      stat_reg      <= stat_next;
      halt_reg      <= halt_next;
      sosc_reg      <= sosc_next;
      fosc_reg      <= fosc_next;
      srun_reg      <= srun_next;
      frun_reg      <= frun_next;
      prun_reg      <= prun_next;
      slow_rst      <= slow_rst_next;
      wr_pend_reg   <= wr_pend_next;
      wr_addr_reg   <= wr_addr_next;
      rdata_reg     <= rdata_next;
      ms_cnt_reg    <= ms_cnt_next;
      step_cnt_reg  <= step_cnt_next;
      ms_tick_reg   <= ms_tick_next;
      step_tick_reg <= step_tick_next;
    end
  end

  // zero-wait slave: hreadyout follows hresetn and hresp is tied low, no flops
  assign hreadyout            = hresetn;
  assign hresp                = 1'b0;
  assign hrdata               = rdata_reg;
  assign cpu_halt             = halt_reg;
  assign wake_enable          = wake_en_reg;
  assign irq_enable           = irq_out_reg;
  assign slow_osc_run         = sosc_reg;
  assign fast_osc_run         = fosc_reg;
  assign slow_wake_timer_run  = srun_reg;
  assign fast_wake_timer_run  = frun_reg;
  assign one_second_pulse_run = prun_reg;
  assign lp_state             = state_reg;

  // ==========================================================
  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_halt_lowpower : assert property ( // see RULE_01
    (state_reg == LPW_ST_STANDBY || state_reg == LPW_ST_SLEEP) |-> cpu_halt)
    else $error("core not halted in low power");
  a_armed_or : assert property ( // see RULE_02
    state_reg == LPW_ST_ACTIVE && req_sb_reg && variant_reg == LPW_VAR_FULL
    && code_reg == `LPW_CODE_PPS |=> armed_reg == ($past(src_reg) | 13'h0800))
    else $error("armed set is not mask OR timer bit");
  a_slow_period : assert property ( // see RULE_03
    state_reg == LPW_ST_ACTIVE && req_sb_reg && variant_reg != LPW_VAR_NOPARAM
    && code_reg >= `LPW_CODE_SLOW_LO && code_reg <= `LPW_CODE_SLOW_HI
    |=> slow_lim_reg == lpw_slow_period($past(code_reg)) ##0 srun_reg && slow_osc_run)
    else $error("slow timer not set up from the code");
  a_fast_count : assert property ( // see RULE_04
    state_reg == LPW_ST_ACTIVE && (req_sb_reg || req_sl_reg) && variant_reg == LPW_VAR_FULL
    && code_reg == 9'h00E |=> fast_lim_reg == 13'h0001 ##0 fast_osc_run)
    else $error("fast count wrong for the first fast code");
  a_nosel_all : assert property ( // see RULE_11
    state_reg == LPW_ST_ACTIVE && (req_sb_reg || req_sl_reg) && variant_reg == LPW_VAR_NOSEL
    |=> armed_reg == `LPW_SRC_ALL)
    else $error("non-selectable variant not armed on all");
  a_var_sleep_irq : assert property ( // see RULE_13
    state_reg == LPW_ST_SLEEP && variant_reg == LPW_VAR_NOPARAM |-> irq_enable == 13'h0000)
    else $error("interrupts open during variant sleep");
  a_wake_exit : assert property ( // see RULE_18
    state_reg == LPW_ST_STANDBY && wake |=> state_reg == LPW_ST_RESTORE
    ##1 state_reg == LPW_ST_ACTIVE && !cpu_halt)
    else $error("wake did not return to active in two cycles");
  a_src_restore : assert property ( // see RULE_19
    state_reg == LPW_ST_RESTORE |=> wake_enable == $past(saved_reg))
    else $error("source enables not restored on exit");
  a_status_read : assert property ( // see RULE_20
    rd_stat && !fast_exp |=> hrdata == {29'h0, $past(stat_reg)} && !stat_reg[`LPW_STAT_FAST])
    else $error("status not returned or not cleared on read");
  a_set_wins : assert property ( // see RULE_20
    rd_stat && slow_exp |=> stat_reg[`LPW_STAT_SLOW])
    else $error("slow flag lost under read clear");

  c_standby_timer : cover property (state_reg == LPW_ST_STANDBY && slow_exp);
  c_sleep_var     : cover property (state_reg == LPW_ST_SLEEP && variant_reg == LPW_VAR_NOPARAM
                                    && wake);
  c_fast_wake     : cover property (state_reg == LPW_ST_STANDBY && fast_exp && wake);
  c_status_read   : cover property (rd_stat && stat_reg != 3'h0);
endmodule
`default_nettype wire

// ---- tb/lpw_evt_src.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lpw_consts.svh"
// ==========================================================
// on-chip wake sources: level requests held until firmware clears them
module lpw_evt_src
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic [`LPW_SRC_W-1:0] raise,
  input  wire logic                  clear,
  output logic      [`LPW_SRC_W-1:0] wake_evt
);
  // sources are level triggered, so a request stays up until serviced
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wake_evt <= '0;
    else if (clear)
      wake_evt <= '0;
    else
      wake_evt <= wake_evt | raise;
endmodule
`default_nettype wire

// ---- tb/lpw_wakeup_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lpw_consts.svh"
module lpw_wakeup_ctrl_tb;
  import lpw_pkg::*;
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [8:0]  code;
    logic [12:0] mask;
    logic [12:0] evt;
    logic [12:0] arm;
    logic [2:0]  stat;
    logic [4:0]  run;
  } lpw_row_t;
  localparam int MS = 20;
  // pulse first: once the slow timer runs it shares the pulse wake bit
  localparam lpw_row_t ROWS [6] = '{
    '{5'h01, 9'h001, 13'h0000, 13'h0000, 13'h0800, 3'h4, 5'h10},
    '{5'h01, 9'h000, 13'h0801, 13'h0001, 13'h0801, 3'h0, 5'h10},
    '{5'h01, 9'h003, 13'h0010, 13'h0000, 13'h0810, 3'h2, 5'h15},
    '{5'h02, 9'h00E, 13'h0200, 13'h0000, 13'h0600, 3'h1, 5'h1F},
    '{5'h05, 9'h000, 13'h0001, 13'h1000, 13'h0000, 3'h0, 5'h1F},
    '{5'h09, 9'h000, 13'h0000, 13'h0080, 13'h0000, 3'h0, 5'h1F}};
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        clear = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] r;
  logic [12:0] raise = 0;
  wire  logic  hready;
  wire  logic  [12:0] wake_evt;
  logic        cpu_halt;
  logic [12:0] wake_enable;
  logic [12:0] irq_enable;
  logic [31:0] hrdata;
  logic        hresp;
  logic [4:0]  run_o;
  lpw_state_t  lp_state;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t [2];
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  lpw_evt_src ev_u (.hclk(hclk), .hresetn(hresetn), .raise(raise), .clear(clear),
    .wake_evt(wake_evt));
  lpw_wakeup_ctrl #(.MS_CYCLES(MS)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .wake_evt(wake_evt),
    .cpu_halt(cpu_halt), .wake_enable(wake_enable), .irq_enable(irq_enable),
    .slow_osc_run(run_o[0]), .fast_osc_run(run_o[1]), .slow_wake_timer_run(run_o[2]),
    .fast_wake_timer_run(run_o[3]), .one_second_pulse_run(run_o[4]), .lp_state(lp_state));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_st(input lpw_state_t s, input int lim);
    int k;
    k = 0;
    while (lp_state !== s && k < lim)
    begin
      @(posedge hclk);
      #1;
      k++;
    end
    chk(32'(lp_state), 32'(s));
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    stop_test;
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    #1;
    chk({hready, cpu_halt, irq_enable, 4'(lp_state)}, {2'b00, 13'h1FFF, 4'h1});
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1, `LPW_OFS_WAKE_SRC, 32'h1FFF);
    ahb(0, `LPW_OFS_WAKE_SRC, 0);
    chk(r, 32'h1EDF);
    chk({31'h0, hresp}, 32'h0);
    ahb(1, 8'h1C, 32'hFFFF);
    ahb(0, 8'h1C, 0);
    chk(r, 32'h0);
    foreach (ROWS[i])
    begin
      ahb(1, `LPW_OFS_SRC_EN, 32'h3);
      ahb(1, `LPW_OFS_WAKE_TIME, 32'(ROWS[i].code));
      ahb(1, `LPW_OFS_WAKE_SRC, 32'(ROWS[i].mask));
      ahb(1, `LPW_OFS_CTRL, 32'(ROWS[i].ctrl));
      repeat (3) @(posedge hclk);
      #1;
      chk({cpu_halt, 4'(lp_state)}, {1'b1, ROWS[i].ctrl[0] ? 4'h2 : 4'h4});
      if (ROWS[i].ctrl[3:2] == 2'h0)
        chk(wake_enable, ROWS[i].arm);
      @(posedge hclk);
      raise <= ROWS[i].evt;
      wait_st(LPW_ST_RESTORE, 21000);
      wait_st(LPW_ST_ACTIVE, 2);
      chk({cpu_halt, wake_enable}, 14'h0003);
      @(posedge hclk);
      raise <= 0;
      clear <= 1'b1;
      @(posedge hclk);
      clear <= 1'b0;
      ahb(0, `LPW_OFS_STATUS, 0);
      chk(r[2:0] & ROWS[i].stat, ROWS[i].stat);
      ahb(0, `LPW_OFS_STATUS, 0);
      chk(r[2:0] & ROWS[i].stat, 3'h0);
      ahb(0, `LPW_OFS_STATE, 0);
      chk({r[8:6], r[5:4] & ROWS[i].run[1:0]}, ROWS[i].run);
      chk({run_o[4:2], run_o[1:0] & ROWS[i].run[1:0]}, ROWS[i].run);
    end
    ahb(1, `LPW_OFS_WAKE_TIME, 32'h3);
    ahb(1, `LPW_OFS_WAKE_SRC, 0);
    for (int j = 0; j < 2; j++)
    begin
      ahb(1, `LPW_OFS_CTRL, 32'h1);
      wait_st(LPW_ST_RESTORE, 200);
      t[j] = cyc;
      wait_st(LPW_ST_ACTIVE, 2);
      ahb(0, `LPW_OFS_STATUS, 0);
    end
    chk(32'(t[1] - t[0]), 32'(4 * MS));
    ahb(1, `LPW_OFS_CTRL, 32'hA);
    repeat (3) @(posedge hclk);
    #1;
    chk({irq_enable, wake_enable}, {13'h0000, 13'h0800});
    @(posedge hclk);
    raise <= 13'h0001;
    repeat (3) @(posedge hclk);
    #1;
    chk(32'(lp_state), 32'(LPW_ST_SLEEP));
    wait_st(LPW_ST_RESTORE, 50);
    wait_st(LPW_ST_ACTIVE, 2);
    chk(irq_enable, 13'h1FFF);
    stop_test;
  end
endmodule
`default_nettype wire
